// ---- sps_sequencer.sv ----
`timescale 1ns/1ps
// How it works
// (R1) driver stops bridge above about 155 C, restarts after hysteresis
// (R2) driver stops bridge under supply lockout, restarts when supply returns
// (R3) wave drive: A, B, A reversed, B reversed, one winding at a time
// (R4) reverse direction walks the chosen table backwards
// (R5) full step: both windings on, polarities AB, A*B, A*B*, AB*
// (R6) half step: angle moves 45 degrees, eight entries per cycle
// (R7) winding A code is |cos| rounded to four bits, msb on top pin
// (R8) each winding polarity bit selects its current direction
// (R9) quarter step: 22.5 degree entries, sixteen per cycle, repeating
// (R10) codes 15,14,11,6,0; A follows cosine, B follows sine
// (R11) polarity A high 0..67.5 and 270..337.5; B high 0..157.5
// (R12) both brake inputs held low while microstepping
// (R13) driver threshold is reference times code over sixteen
// (R14) wrapping index per mode, stepped up or down per request
module sps_sequencer
  import sps_pkg::*;
#(
  parameter int unsigned RATE_W = SPS_RATE_W
)
(
  input  wire logic              clk_sys_i,
  input  wire logic              rst_n_i,
  input  wire sps_mode_type      mode_i,
  input  wire logic              step_i,
  input  wire logic              reverse_i,
  input  wire logic              enable_i,
  input  wire logic              brake_i,
  input  wire logic [RATE_W-1:0] rate_i,
  output logic                   magnitude_msb_a_o,
  output logic                   magnitude_a2_o,
  output logic                   magnitude_a1_o,
  output logic                   magnitude_lsb_a_o,
  output logic                   polarity_a_o,
  output logic                   winding_short_a_o,
  output logic                   magnitude_msb_b_o,
  output logic                   magnitude_b2_o,
  output logic                   magnitude_b1_o,
  output logic                   magnitude_lsb_b_o,
  output logic                   polarity_b_o,
  output logic                   winding_short_b_o,
  output logic [3:0]             step_index_o,
  output logic                   step_done_o
);

  logic [3:0]   idx_q;
  logic [3:0]   idx_d;
  logic [3:0]   angle_a;
  logic [3:0]   angle_b;
  logic [3:0]   rom_mag_a;
  logic [3:0]   rom_mag_b;
  logic         rom_pol_a;
  logic         rom_pol_b;
  logic [3:0]   mag_a_d;
  logic [3:0]   mag_b_d;
  logic         pol_a_d;
  logic         pol_b_d;
  logic [3:0]   mag_a_q;
  logic [3:0]   mag_b_q;
  logic         pol_a_q;
  logic         pol_b_q;
  logic         short_q;
  logic         auto_tick;
  logic         adv;
  logic         done_q;
  logic [3:0]   last_idx;
  sps_mode_type mode_q;

  // periodic ticks are ORed with explicit requests; a tick in the same cycle as a request makes one step
  sps_step_div #(
    .RATE_W (RATE_W)
  ) u_div (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .period_i  (rate_i),
    .tick_o    (auto_tick)
  );

  assign adv = enable_i && (step_i || auto_tick);

  // wrap point depends on table length
  always_comb
  begin
    unique case (mode_q)
      SPS_MODE_WAVE:    last_idx = 4'(SPS_LEN_WAVE - 1);
      SPS_MODE_FULL:    last_idx = 4'(SPS_LEN_FULL - 1);
      SPS_MODE_HALF:    last_idx = 4'(SPS_LEN_HALF - 1);
      SPS_MODE_QUARTER: last_idx = 4'(SPS_LEN_QUART - 1);
    endcase
  end

  // wrapping index, up or down
  always_comb
  begin
    idx_d = idx_q;
    if (adv)
    begin
      if (reverse_i) // R4
        idx_d = (idx_q == 4'h0) ? last_idx : idx_q - 4'h1; // R14
      else
        idx_d = (idx_q >= last_idx) ? 4'h0 : idx_q + 4'h1; // R14
    end
  end

  // mode change restarts the table so index never exceeds the new length
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      mode_q <= SPS_MODE_WAVE;
      idx_q  <= SPS_IDX_RST;
    end
    else if (mode_i != mode_q)
    begin
      mode_q <= mode_i;
      idx_q  <= SPS_IDX_RST;
    end
    else
      idx_q <= idx_d;
  end

  // map index to a sixteenth-cycle angle; sine is cosine shifted by 270
  always_comb
  begin
    unique case (mode_q)
      SPS_MODE_HALF:    angle_a = {idx_q[2:0], 1'b0}; // R6
      SPS_MODE_QUARTER: angle_a = idx_q; // R9
      default:          angle_a = {idx_q[1:0], 2'b00};
    endcase
    angle_b = angle_a + 4'hc;
  end

  sps_cos_rom u_rom_a (
    .angle_i (angle_a),
    .mag_o   (rom_mag_a),
    .pol_o   (rom_pol_a)
  );

  sps_cos_rom u_rom_b (
    .angle_i (angle_b),
    .mag_o   (rom_mag_b),
    .pol_o   (rom_pol_b)
  );

  // per-mode pattern; B polarity high through 0..157.5
  always_comb
  begin
    mag_a_d = rom_mag_a; // R7 R10
    mag_b_d = rom_mag_b; // R10
    pol_a_d = rom_pol_a; // R8 R11
    pol_b_d = (angle_a <= 4'h7); // R8 R11
    unique case (mode_q)
      SPS_MODE_WAVE:
      begin
        // only one winding carries current per entry
        mag_a_d = idx_q[0] ? SPS_MAG_ZERO : SPS_MAG_FULL; // R3
        mag_b_d = idx_q[0] ? SPS_MAG_FULL : SPS_MAG_ZERO; // R3
        pol_a_d = ~idx_q[1]; // R3
        pol_b_d = ~idx_q[1]; // R3
      end
      SPS_MODE_FULL:
      begin
        // AB, A*B, A*B*, AB*
        mag_a_d = SPS_MAG_FULL; // R5
        mag_b_d = SPS_MAG_FULL; // R5
        pol_a_d = (idx_q[1:0] == 2'h0) || (idx_q[1:0] == 2'h3); // R5
        pol_b_d = ~idx_q[1]; // R5
      end
      default:
      begin
      end
    endcase
  end

  // registered pin outputs; enable low de-energizes both windings
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      mag_a_q <= SPS_MAG_ZERO;
      mag_b_q <= SPS_MAG_ZERO;
      pol_a_q <= 1'b0;
      pol_b_q <= 1'b0;
    end
    else
    begin
      mag_a_q <= enable_i ? mag_a_d : SPS_MAG_ZERO; // R13
      mag_b_q <= enable_i ? mag_b_d : SPS_MAG_ZERO; // R13
      pol_a_q <= pol_a_d;
      pol_b_q <= pol_b_d;
    end
  end

  // brake only allowed outside microstepping modes
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      short_q <= 1'b0;
    else
      short_q <= brake_i && (mode_i != SPS_MODE_HALF) && (mode_i != SPS_MODE_QUARTER); // R12
  end

  // step acknowledge, set on the same edge that moves the index
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      done_q <= 1'b0;
    else
      done_q <= adv && (mode_i == mode_q);
  end

  // msb on the highest pin, driver weights code over sixteen
  assign magnitude_msb_a_o = mag_a_q[3]; // R7 R13
  assign magnitude_a2_o    = mag_a_q[2];
  assign magnitude_a1_o    = mag_a_q[1];
  assign magnitude_lsb_a_o = mag_a_q[0];
  assign magnitude_msb_b_o = mag_b_q[3];
  assign magnitude_b2_o    = mag_b_q[2];
  assign magnitude_b1_o    = mag_b_q[1];
  assign magnitude_lsb_b_o = mag_b_q[0];
  assign polarity_a_o      = pol_a_q;
  assign polarity_b_o      = pol_b_q;
  assign winding_short_a_o = short_q;
  assign winding_short_b_o = short_q;
  assign step_index_o      = idx_q;
  assign step_done_o       = done_q;

  // thermal and undervoltage shutdown are inside the driver (R1 R2);
  // the sequencer keeps its index so motion resumes on restart

  property p_idx_wrap;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (adv && !reverse_i && idx_q == last_idx && mode_i == mode_q) |=> idx_q == 4'h0;
  endproperty
  a_idx_wrap: assert property (p_idx_wrap) else $error("index did not wrap"); // R14

  property p_idx_back;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (adv && reverse_i && idx_q == 4'h0 && mode_i == mode_q) |=> idx_q == $past(last_idx);
  endproperty
  a_idx_back: assert property (p_idx_back) else $error("reverse wrap wrong"); // R4

  property p_idx_hold;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (!adv && mode_i == mode_q) |=> $stable(idx_q);
  endproperty
  a_idx_hold: assert property (p_idx_hold) else $error("index moved without step"); // R14

  property p_wave_one;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (mode_q == SPS_MODE_WAVE && enable_i && mode_i == mode_q)
        |=> (mag_a_q == SPS_MAG_ZERO) != (mag_b_q == SPS_MAG_ZERO);
  endproperty
  a_wave_one: assert property (p_wave_one) else $error("wave drive not single winding"); // R3

  property p_full_both;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (mode_q == SPS_MODE_FULL && enable_i) |=> mag_a_q == SPS_MAG_FULL && mag_b_q == SPS_MAG_FULL;
  endproperty
  a_full_both: assert property (p_full_both) else $error("full step winding off"); // R5

  property p_quart_zero;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (mode_q == SPS_MODE_QUARTER && enable_i && idx_q == 4'h0)
        |=> mag_a_q == 4'hf && mag_b_q == 4'h0 && pol_a_q && pol_b_q;
  endproperty
  a_quart_zero: assert property (p_quart_zero) else $error("quarter entry 0 wrong"); // R10

  property p_quart_pol;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (mode_q == SPS_MODE_QUARTER && idx_q == 4'h4) |=> !pol_a_q && pol_b_q && mag_a_q == 4'h0;
  endproperty
  a_quart_pol: assert property (p_quart_pol) else $error("quarter 90 deg wrong"); // R11

  property p_half_45;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (mode_q == SPS_MODE_HALF && enable_i && idx_q == 4'h1)
        |=> mag_a_q == 4'hb && mag_b_q == 4'hb;
  endproperty
  a_half_45: assert property (p_half_45) else $error("half step 45 deg wrong"); // R6

  property p_no_brake;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (mode_i == SPS_MODE_QUARTER || mode_i == SPS_MODE_HALF)
        |=> !winding_short_a_o && !winding_short_b_o;
  endproperty
  a_no_brake: assert property (p_no_brake) else $error("brake during microstep"); // R12

  // acknowledge stands exactly one cycle per accepted step
  property p_done_set;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (adv && mode_i == mode_q) |=> step_done_o;
  endproperty
  a_done_set: assert property (p_done_set) else $error("step not acknowledged"); // R14

  property p_done_clear;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      !adv |=> !step_done_o;
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("acknowledge without step"); // R14

  c_quart_wrap: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    mode_q == SPS_MODE_QUARTER && adv && idx_q == 4'hf);
  c_reverse: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    adv && reverse_i && idx_q == 4'h0);
  c_wave: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    mode_q == SPS_MODE_WAVE && adv);

endmodule

// ---- sps_pkg.sv ----
package sps_pkg;
  // drive modes
  typedef enum logic [1:0] {
    SPS_MODE_WAVE,
    SPS_MODE_FULL,
    SPS_MODE_HALF,
    SPS_MODE_QUARTER
  } sps_mode_type;

  // table geometry: in quarter step the index counts sixteenths of an electrical cycle
  localparam int unsigned SPS_IDX_W      = 4;
  localparam int unsigned SPS_MAG_W      = 4;
  localparam int unsigned SPS_LEN_WAVE   = 4;
  localparam int unsigned SPS_LEN_FULL   = 4;
  localparam int unsigned SPS_LEN_HALF   = 8;
  localparam int unsigned SPS_LEN_QUART  = 16;

  // magnitude codes for |cos| at 22.5 degree points
  localparam logic [3:0] SPS_MAG_1P000 = 4'hf; // 15
  localparam logic [3:0] SPS_MAG_0P924 = 4'he; // 14
  localparam logic [3:0] SPS_MAG_0P707 = 4'hb; // 11
  localparam logic [3:0] SPS_MAG_0P383 = 4'h6; // 6
  localparam logic [3:0] SPS_MAG_ZERO  = 4'h0;
  localparam logic [3:0] SPS_MAG_FULL  = 4'hf; // full-step current

  // reset values
  localparam logic [3:0] SPS_IDX_RST   = 4'h0;

  // step-rate divider width; rate counts cycles between auto steps (0 = off)
  localparam int unsigned SPS_RATE_W   = 16;
endpackage

// ---- sps_cos_rom.sv ----
`timescale 1ns/1ps
// magnitude and polarity for one winding at a sixteenth-cycle angle
module sps_cos_rom
  import sps_pkg::*;
(
  input  wire logic [3:0] angle_i,
  output logic      [3:0] mag_o,
  output logic            pol_o
);

  // |cos| folded over the quarter cycle
  always_comb
  begin
    unique case (angle_i[1:0])
      2'h0:    mag_o = angle_i[2] ? SPS_MAG_ZERO  : SPS_MAG_1P000;
      2'h1:    mag_o = angle_i[2] ? SPS_MAG_0P383 : SPS_MAG_0P924;
      2'h2:    mag_o = SPS_MAG_0P707;
      default: mag_o = angle_i[2] ? SPS_MAG_0P924 : SPS_MAG_0P383;
    endcase
  end

  // polarity 1 for 0..67.5 and 270..337.5
  assign pol_o = (angle_i <= 4'h3) || (angle_i >= 4'hc); // R11

endmodule

// ---- sps_step_div.sv ----
`timescale 1ns/1ps
// programmable step-rate divider, one-cycle pulse
module sps_step_div
  import sps_pkg::*;
#(
  parameter int unsigned RATE_W = SPS_RATE_W
)
(
  input  wire logic              clk_sys_i,
  input  wire logic              rst_n_i,
  input  wire logic [RATE_W-1:0] period_i,
  output logic                   tick_o
);

  logic [RATE_W-1:0] cnt_q;

  // period of zero disables auto stepping
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i || period_i == '0 || cnt_q >= period_i - 1'b1)
      cnt_q <= '0;
    else
      cnt_q <= cnt_q + 1'b1;
  end

  assign tick_o = (period_i != '0) && (cnt_q >= period_i - 1'b1);

endmodule

// ---- sps_drv_model.sv ----
`timescale 1ns/1ps
// behavioural full-bridge driver for one winding
module sps_drv_model #(
  parameter int HOT_C   = 155,
  parameter int HYST_C  = 5,    // slight hysteresis, exact value not fixed
  parameter int UVLO_MV = 6500  // somewhere in the 5 V to 8 V band
)
(
  input  wire logic [3:0] code_i,
  input  wire logic       dir_i,
  input  wire logic       short_i,
  input  int              temp_c_i,
  input  int              vcc_mv_i,
  output logic            bridge_on_o,
  output logic [4:0]      drive_o
);
  logic hot_q = 1'b0;
  // thermal latch, restarts only once cooled past the hysteresis
  always @(temp_c_i)
  begin
    if (temp_c_i > HOT_C)
      hot_q = 1'b1;
    else if (temp_c_i < HOT_C - HYST_C)
      hot_q = 1'b0;
  end
  // bridge off while hot or under lockout; level is code/16 of reference
  assign bridge_on_o = !hot_q && (vcc_mv_i >= UVLO_MV);
  assign drive_o = (bridge_on_o && !short_i) ? {dir_i, code_i} : 5'h00;
endmodule

// ---- tb_sps_sequencer.sv ----
`timescale 1ns/1ps
module tb_sps_sequencer;
  import sps_pkg::*;
  logic         clk_sys_i = 1'b0;
  logic         rst_n_i   = 1'b0;
  sps_mode_type mode_i    = SPS_MODE_WAVE;
  logic         step_i    = 1'b0;
  logic         reverse_i = 1'b0;
  logic         enable_i  = 1'b1;
  logic         brake_i   = 1'b0;
  logic [15:0]  rate_i    = 16'h0000;
  logic         ma3, ma2, ma1, ma0, pa, sa, mb3, mb2, mb1, mb0, pb, sb, done, on_a, on_b;
  logic [3:0]   idx;
  logic [4:0]   drv_a, drv_b;
  logic [9:0]   pins;
  logic         got_done = 1'b0;
  int           temp_c = 25, vcc_mv = 24000, fails = 0, checked = 0, cycles = 0;
  logic [3:0]   lut [5] = '{4'hf, 4'he, 4'hb, 4'h6, 4'h0};
  // mode, reverse, index expected after one step
  logic [6:0]   rows [15] = '{7'h01, 7'h02, 7'h03, 7'h00, 7'h13, 7'h21, 7'h30, 7'h33,
                              7'h57, 7'h40, 7'h41, 7'h61, 7'h70, 7'h7f, 7'h7e};

  sps_sequencer i_sps_sequencer (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .mode_i(mode_i),
    .step_i(step_i), .reverse_i(reverse_i), .enable_i(enable_i), .brake_i(brake_i),
    .rate_i(rate_i), .magnitude_msb_a_o(ma3), .magnitude_a2_o(ma2), .magnitude_a1_o(ma1),
    .magnitude_lsb_a_o(ma0), .polarity_a_o(pa), .winding_short_a_o(sa),
    .magnitude_msb_b_o(mb3), .magnitude_b2_o(mb2), .magnitude_b1_o(mb1),
    .magnitude_lsb_b_o(mb0), .polarity_b_o(pb), .winding_short_b_o(sb),
    .step_index_o(idx), .step_done_o(done));
  sps_drv_model i_sps_drv_model_a (.code_i({ma3, ma2, ma1, ma0}), .dir_i(pa), .short_i(sa),
    .temp_c_i(temp_c), .vcc_mv_i(vcc_mv), .bridge_on_o(on_a), .drive_o(drv_a));
  sps_drv_model i_sps_drv_model_b (.code_i({mb3, mb2, mb1, mb0}), .dir_i(pb), .short_i(sb),
    .temp_c_i(temp_c), .vcc_mv_i(vcc_mv), .bridge_on_o(on_b), .drive_o(drv_b));

  assign pins = {ma3, ma2, ma1, ma0, pa, mb3, mb2, mb1, mb0, pb};
  always #2 clk_sys_i = ~clk_sys_i;

  // hang guard, run needs about 110 cycles
  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      fails++;
      report_and_stop();
    end
  end

  // |cos| code at a sixteenth-cycle angle, period is half a cycle
  function automatic logic [3:0] qm(input logic [3:0] a);
    logic [2:0] k;
    k = a[2:0];
    return (k > 3'h4) ? lut[3'h0 - k] : lut[k];
  endfunction

  function automatic logic [9:0] exp_pins(input logic [1:0] m, input logic [3:0] i);
    logic [3:0] a;
    a = (m == 2'h2) ? {i[2:0], 1'b0} : i;
    if (m == 2'h0)
      return {i[0] ? 4'h0 : 4'hf, ~i[1], i[0] ? 4'hf : 4'h0, ~i[1]};
    if (m == 2'h1)
      return {4'hf, i == 4'h0 || i == 4'h3, 4'hf, ~i[1]};
    return {qm(a), a < 4'h4 || a > 4'hb, qm(a - 4'h4), ~a[3]};
  endfunction

  task automatic chk(input logic [9:0] got, input logic [9:0] want);
    checked++;
    if (got !== want)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  // outputs are checked while reset is still held; the first edge after
  // release already registers table entry 0
  task automatic do_reset();
    rst_n_i = 1'b0;
    repeat (12) @(negedge clk_sys_i);
    chk(pins, 10'h000);
    chk({3'h0, idx, done, sa, sb}, 10'h000);
    rst_n_i = 1'b1;
    @(negedge clk_sys_i);
  endtask

  // one request; returns when the new entry is on the pins
  // done rises with the index, so it is caught between the two edges
  task automatic step(input logic rev);
    reverse_i = rev;
    step_i = 1'b1;
    @(negedge clk_sys_i);
    step_i = 1'b0;
    got_done = done;
    @(negedge clk_sys_i);
  endtask

  task automatic report_and_stop();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    do_reset();
    chk({6'h00, idx}, 10'h000);
    chk(pins, exp_pins(2'h0, 4'h0));
    $display("reset done");
    for (int r = 0; r < 15; r++)
    begin
      if (rows[r][6:5] != mode_i)
      begin
        mode_i = sps_mode_type'(rows[r][6:5]);
        repeat (3) @(negedge clk_sys_i);
      end
      step(rows[r][4]);
      chk({6'h00, idx}, {6'h00, rows[r][3:0]});
      chk(pins, exp_pins(rows[r][6:5], rows[r][3:0]));
      chk({7'h00, got_done, done, sa | sb}, 10'h004);
    end
    $display("table rows done");
    // back-to-back forward requests wrap the quarter table from 14 to 4
    reverse_i = 1'b0;
    step_i = 1'b1;
    repeat (6) @(negedge clk_sys_i);
    step_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    chk({6'h00, idx}, 10'h004);
    chk(pins, exp_pins(2'h3, 4'h4));
    brake_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    chk({8'h00, sa, sb}, 10'h000);
    mode_i = SPS_MODE_WAVE;
    repeat (3) @(negedge clk_sys_i);
    chk({8'h00, sa, sb}, 10'h003);
    brake_i = 1'b0;
    enable_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    step(1'b0);
    chk({idx, ma3, ma2, ma1, ma0, mb3, mb2}, 10'h000);
    chk({9'h000, got_done}, 10'h000);
    // period 4 ticks on every fourth edge: five steps in twenty cycles
    enable_i = 1'b1;
    rate_i = 16'h0004;
    repeat (20) @(negedge clk_sys_i);
    rate_i = 16'h0000;
    repeat (3) @(negedge clk_sys_i);
    chk({6'h00, idx}, 10'h001);
    $display("edge cases done");
    chk({5'h00, drv_a}, {5'h00, pa, ma3, ma2, ma1, ma0});
    temp_c = 160;
    #1 chk({8'h00, on_a, on_b}, 10'h000);
    temp_c = 152;
    #1 chk({8'h00, on_a, on_b}, 10'h000);
    temp_c = 140;
    #1 chk({8'h00, on_a, on_b}, 10'h003);
    vcc_mv = 5000;
    #1 chk({8'h00, on_a, on_b}, 10'h000);
    vcc_mv = 24000;
    #1 chk({8'h00, on_a, on_b}, 10'h003);
    $display("driver model done");
    @(negedge clk_sys_i);
    do_reset();
    chk({6'h00, idx}, 10'h000);
    chk(pins, exp_pins(2'h0, 4'h0));
    chk({8'h00, done, pb}, 10'h001);
    $display("second reset done");
    report_and_stop();
  end
endmodule
